// *** crs_defines.svh ***
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH

// ==========================================================================
// widths and counts
`define CRS_XLEN 32
`define CRS_NGPR 32
`define CRS_IDX_W 5
`define CRS_PC_BITS 26
`define CRS_PSW_BITS 8
`define CRS_PIPE_STAGES 5
`define CRS_BIT_IDX_W 3
`define CRS_SHAMT_W 5

// ==========================================================================
// special general register indices
`define CRS_ZERO_IDX 5'h00
`define CRS_EP_IDX 5'h1e

// ==========================================================================
// reset values
`define CRS_PSW_RST 8'h20
`define CRS_PC_RST 26'h000_0000
`define CRS_WORD_RST 32'h0000_0000

// ==========================================================================
// system register numbers
`define CRS_SR_IRQ_PC 5'h00
`define CRS_SR_IRQ_PSW 5'h01
`define CRS_SR_NMI_PC 5'h02
`define CRS_SR_NMI_PSW 5'h03
`define CRS_SR_CAUSE 5'h04
`define CRS_SR_PSW 5'h05
`define CRS_SR_TC_PC 5'h10
`define CRS_SR_TC_PSW 5'h11
`define CRS_SR_DBG_PC 5'h12
`define CRS_SR_DBG_PSW 5'h13
`define CRS_SR_TC_BASE 5'h14

// ==========================================================================
// timing
`define CRS_CLK_MHZ 20
`define CRS_MIN_EXEC_NS 50

`endif

// *** crs_pkg.sv ***
package crs_pkg;

  // single-cycle shift and bit manipulation operations
  typedef enum logic [2:0] {
    CRS_OP_NONE = 3'h0,
    CRS_OP_SHL = 3'h1,
    CRS_OP_SHR = 3'h2,
    CRS_OP_SAR = 3'h3,
    CRS_OP_BIT_SET = 3'h4,
    CRS_OP_BIT_CLEAR = 3'h5,
    CRS_OP_BIT_INVERT = 3'h6,
    CRS_OP_BIT_TEST = 3'h7
  } crs_op_t;

  // exceptional entries that save context
  typedef enum logic [2:0] {
    CRS_EVT_NONE = 3'h0,
    CRS_EVT_IRQ = 3'h1,
    CRS_EVT_NMI = 3'h2,
    CRS_EVT_DEBUG = 3'h3,
    CRS_EVT_TABLE_CALL = 3'h4
  } crs_evt_t;

  // returns that restore context
  typedef enum logic [2:0] {
    CRS_RET_NONE = 3'h0,
    CRS_RET_IRQ = 3'h1,
    CRS_RET_NMI = 3'h2,
    CRS_RET_DEBUG = 3'h3,
    CRS_RET_TABLE_CALL = 3'h4
  } crs_ret_t;

endpackage : crs_pkg

// *** crs_alu_if.sv ***
`timescale 1ns/1ps
`include "crs_defines.svh"

interface crs_alu_if;
  crs_pkg::crs_op_t op;
  logic [`CRS_XLEN-1:0] operand;
  logic [`CRS_SHAMT_W-1:0] amount;
  logic [`CRS_XLEN-1:0] result;
  logic bit_was_zero;

  modport core (output op, output operand, output amount, input result, input bit_was_zero);
  modport unit (input op, input operand, input amount, output result, output bit_was_zero);
endinterface : crs_alu_if

// *** crs_shift_bit.sv ***
`timescale 1ns/1ps
`include "crs_defines.svh"

module crs_shift_bit (
  // operation
  crs_alu_if.unit alu
);

  logic [`CRS_BIT_IDX_W-1:0] bit_idx;
  logic [`CRS_XLEN-1:0] bit_mask;

  // bit operations address one bit of a memory byte, so only the low index bits count
  assign bit_idx = alu.amount[`CRS_BIT_IDX_W-1:0];
  assign bit_mask = {{(`CRS_XLEN-1){1'b0}}, 1'b1} << bit_idx;
  assign alu.bit_was_zero = ((alu.operand & bit_mask) == '0);

  // a full barrel shifter keeps any 32-bit shift to one clock
  always_comb
  begin
    case (alu.op)
      crs_pkg::CRS_OP_SHL: alu.result = alu.operand << alu.amount;
      crs_pkg::CRS_OP_SHR: alu.result = alu.operand >> alu.amount;
      crs_pkg::CRS_OP_SAR: alu.result = $signed(alu.operand) >>> alu.amount;
      crs_pkg::CRS_OP_BIT_SET: alu.result = alu.operand | bit_mask;
      crs_pkg::CRS_OP_BIT_CLEAR: alu.result = alu.operand & ~bit_mask;
      crs_pkg::CRS_OP_BIT_INVERT: alu.result = alu.operand ^ bit_mask;
      crs_pkg::CRS_OP_BIT_TEST: alu.result = alu.operand;
      default: alu.result = alu.operand;
    endcase
  end

endmodule : crs_shift_bit

// *** crs_regs.sv ***
// How it works
// - thirty-two general registers hold data or addresses
// - register zero always reads as zero
// - short loads and stores use register thirty base
// - every general register is thirty-two bits wide
// - fetch covers 64 MB, data covers 4 GB
// - five-stage pipeline retires one per clock
// - minimum execution time is 50 ns
// - a 32-bit shift finishes in one clock
// - bit set, clear, invert and test supported
// - program counter holds current instruction address
// - system registers keep interrupt, trap, table-call state
// - counter keeps 26 bits, bit zero cleared
`timescale 1ns/1ps
`include "crs_defines.svh"

module crs_regs #(
  parameter int XLEN = `CRS_XLEN,
  parameter int NGPR = `CRS_NGPR,
  parameter int PIPE_STAGES = `CRS_PIPE_STAGES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // general register read ports, answered one clock later
  input wire logic [`CRS_IDX_W-1:0] rd_a_idx_i,
  input wire logic [`CRS_IDX_W-1:0] rd_b_idx_i,
  output logic [XLEN-1:0] rd_a_data_o,
  output logic [XLEN-1:0] rd_b_data_o,
  // general register write port
  input wire logic wr_en_i,
  input wire logic [`CRS_IDX_W-1:0] wr_idx_i,
  input wire logic [XLEN-1:0] wr_data_i,
  // data address generation
  input wire logic addr_req_i,
  input wire logic short_fmt_i,
  input wire logic [XLEN-1:0] addr_offset_i,
  output logic [XLEN-1:0] data_addr_o,
  // shift and bit manipulation
  input wire crs_pkg::crs_op_t op_i,
  input wire logic [XLEN-1:0] op_operand_i,
  input wire logic [`CRS_SHAMT_W-1:0] op_amount_i,
  output logic [XLEN-1:0] op_result_o,
  output logic op_bit_zero_o,
  // program counter
  input wire logic pc_load_i,
  input wire logic [XLEN-1:0] pc_target_i,
  input wire logic pc_advance_i,
  input wire logic [2:0] pc_step_i,
  output logic [XLEN-1:0] pc_o,
  output logic [`CRS_PC_BITS-1:0] fetch_addr_o,
  // system register access
  input wire logic sr_wr_i,
  input wire logic [`CRS_IDX_W-1:0] sr_idx_i,
  input wire logic [XLEN-1:0] sr_wdata_i,
  output logic [XLEN-1:0] sr_rdata_o,
  output logic [`CRS_PSW_BITS-1:0] psw_o,
  output logic debug_window_o,
  // exception entry and return
  input wire crs_pkg::crs_evt_t evt_i,
  input wire logic [XLEN-1:0] evt_pc_i,
  input wire logic [XLEN-1:0] evt_cause_i,
  input wire crs_pkg::crs_ret_t ret_i,
  // pipeline occupancy
  input wire logic issue_i,
  output logic retire_o
);

  // ==========================================================================
  // elaboration checks
  localparam int MIN_EXEC_CYC =
    (`CRS_MIN_EXEC_NS * `CRS_CLK_MHZ + 999) / 1000;

  generate
    if (XLEN != `CRS_XLEN || NGPR != `CRS_NGPR)
    begin : g_bad_width
      $error("crs_regs: only 32 registers of 32 bits are supported");
    end
    if (PIPE_STAGES < 2 || MIN_EXEC_CYC != 1)
    begin : g_bad_pipe
      $error("crs_regs: pipeline must issue one instruction per clock");
    end
  endgenerate

  // ==========================================================================
  // helpers
  function automatic logic [XLEN-1:0] crs_pc_fix(input logic [XLEN-1:0] v);
    // upper bits and bit zero never hold state, so odd or wide values fold away
    crs_pc_fix = {{(XLEN-`CRS_PC_BITS){1'b0}}, v[`CRS_PC_BITS-1:1], 1'b0};
  endfunction : crs_pc_fix

  function automatic logic [XLEN-1:0] crs_psw_ext(input logic [`CRS_PSW_BITS-1:0] v);
    crs_psw_ext = {{(XLEN-`CRS_PSW_BITS){1'b0}}, v};
  endfunction : crs_psw_ext

  // ==========================================================================
  // general registers
  logic [XLEN-1:0] gpr_r [NGPR];

  function automatic logic [XLEN-1:0] crs_gpr_rd(input logic [`CRS_IDX_W-1:0] idx,
                                                 input logic [XLEN-1:0] regs [NGPR]);
    crs_gpr_rd = (idx == `CRS_ZERO_IDX) ? '0 : regs[idx];
  endfunction : crs_gpr_rd

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < NGPR; i++)
      begin
        gpr_r[i] <= `CRS_WORD_RST;
      end
    end
    else if (wr_en_i && wr_idx_i != `CRS_ZERO_IDX)
    begin
      gpr_r[wr_idx_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rd_a_data_o <= `CRS_WORD_RST;
      rd_b_data_o <= `CRS_WORD_RST;
    end
    else
    begin
      rd_a_data_o <= crs_gpr_rd(rd_a_idx_i, gpr_r);
      rd_b_data_o <= crs_gpr_rd(rd_b_idx_i, gpr_r);
    end
  end

  // ==========================================================================
  // data address: full 32-bit logical space, wraps at 4 GB
  logic [XLEN-1:0] addr_base;

  assign addr_base = short_fmt_i ? crs_gpr_rd(`CRS_EP_IDX, gpr_r)
                                 : crs_gpr_rd(rd_a_idx_i, gpr_r);

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      data_addr_o <= `CRS_WORD_RST;
    end
    else if (addr_req_i)
    begin
      data_addr_o <= addr_base + addr_offset_i;
    end
  end

  // ==========================================================================
  // shift and bit unit
  crs_alu_if alu ();

  assign alu.op = op_i;
  assign alu.operand = op_operand_i;
  assign alu.amount = op_amount_i;

  crs_shift_bit u_shift_bit (
    .alu (alu.unit)
  );

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      op_result_o <= `CRS_WORD_RST;
      op_bit_zero_o <= 1'b0;
    end
    else if (op_i != crs_pkg::CRS_OP_NONE)
    begin
      op_result_o <= alu.result;
      op_bit_zero_o <= alu.bit_was_zero;
    end
  end

  // ==========================================================================
  // system registers
  logic [XLEN-1:0] irq_saved_counter_r;
  logic [`CRS_PSW_BITS-1:0] irq_saved_status_r;
  logic [XLEN-1:0] nmi_saved_counter_r;
  logic [`CRS_PSW_BITS-1:0] nmi_saved_status_r;
  logic [XLEN-1:0] exception_cause_r;
  logic [`CRS_PSW_BITS-1:0] program_status_word_r;
  logic [XLEN-1:0] table_call_saved_counter_r;
  logic [`CRS_PSW_BITS-1:0] table_call_saved_status_r;
  logic [XLEN-1:0] debug_trap_saved_counter_r;
  logic [`CRS_PSW_BITS-1:0] debug_trap_saved_status_r;
  logic [XLEN-1:0] table_call_base_r;
  logic debug_window_r;
  logic [XLEN-1:0] pc_r;
  logic [XLEN-1:0] sr_rdata_nxt;
  logic sr_wr_ok;

  // an entry in the same cycle wins over a software write
  assign sr_wr_ok = sr_wr_i && evt_i == crs_pkg::CRS_EVT_NONE;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      irq_saved_counter_r <= `CRS_WORD_RST;
      irq_saved_status_r <= '0;
      nmi_saved_counter_r <= `CRS_WORD_RST;
      nmi_saved_status_r <= '0;
      exception_cause_r <= `CRS_WORD_RST;
      table_call_saved_counter_r <= `CRS_WORD_RST;
      table_call_saved_status_r <= '0;
      debug_trap_saved_counter_r <= `CRS_WORD_RST;
      debug_trap_saved_status_r <= '0;
      table_call_base_r <= `CRS_WORD_RST;
    end
    else if (evt_i == crs_pkg::CRS_EVT_IRQ)
    begin
      irq_saved_counter_r <= crs_pc_fix(evt_pc_i);
      irq_saved_status_r <= program_status_word_r;
      exception_cause_r <= evt_cause_i;
    end
    else if (evt_i == crs_pkg::CRS_EVT_NMI)
    begin
      nmi_saved_counter_r <= crs_pc_fix(evt_pc_i);
      nmi_saved_status_r <= program_status_word_r;
      exception_cause_r <= evt_cause_i;
    end
    else if (evt_i == crs_pkg::CRS_EVT_DEBUG)
    begin
      debug_trap_saved_counter_r <= crs_pc_fix(evt_pc_i);
      debug_trap_saved_status_r <= program_status_word_r;
    end
    else if (evt_i == crs_pkg::CRS_EVT_TABLE_CALL)
    begin
      table_call_saved_counter_r <= crs_pc_fix(evt_pc_i);
      table_call_saved_status_r <= program_status_word_r;
    end
    else if (sr_wr_ok)
    begin
      // the cause register is read-only and reserved numbers drop the write
      if (sr_idx_i == `CRS_SR_IRQ_PC)
        irq_saved_counter_r <= crs_pc_fix(sr_wdata_i);
      else if (sr_idx_i == `CRS_SR_IRQ_PSW)
        irq_saved_status_r <= sr_wdata_i[`CRS_PSW_BITS-1:0];
      else if (sr_idx_i == `CRS_SR_NMI_PC)
        nmi_saved_counter_r <= crs_pc_fix(sr_wdata_i);
      else if (sr_idx_i == `CRS_SR_NMI_PSW)
        nmi_saved_status_r <= sr_wdata_i[`CRS_PSW_BITS-1:0];
      else if (sr_idx_i == `CRS_SR_TC_PC)
        table_call_saved_counter_r <= crs_pc_fix(sr_wdata_i);
      else if (sr_idx_i == `CRS_SR_TC_PSW)
        table_call_saved_status_r <= sr_wdata_i[`CRS_PSW_BITS-1:0];
      else if (sr_idx_i == `CRS_SR_DBG_PC && debug_window_r)
        debug_trap_saved_counter_r <= crs_pc_fix(sr_wdata_i);
      else if (sr_idx_i == `CRS_SR_DBG_PSW && debug_window_r)
        debug_trap_saved_status_r <= sr_wdata_i[`CRS_PSW_BITS-1:0];
      else if (sr_idx_i == `CRS_SR_TC_BASE)
        table_call_base_r <= sr_wdata_i;
    end
  end

  // status word: a return restores it, a write takes effect on the next clock
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      program_status_word_r <= `CRS_PSW_RST;
    else if (ret_i == crs_pkg::CRS_RET_IRQ)
      program_status_word_r <= irq_saved_status_r;
    else if (ret_i == crs_pkg::CRS_RET_NMI)
      program_status_word_r <= nmi_saved_status_r;
    else if (ret_i == crs_pkg::CRS_RET_DEBUG)
      program_status_word_r <= debug_trap_saved_status_r;
    else if (ret_i == crs_pkg::CRS_RET_TABLE_CALL)
      program_status_word_r <= table_call_saved_status_r;
    else if (sr_wr_ok && sr_idx_i == `CRS_SR_PSW)
      program_status_word_r <= sr_wdata_i[`CRS_PSW_BITS-1:0];
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      debug_window_r <= 1'b0;
    else if (evt_i == crs_pkg::CRS_EVT_DEBUG)
      debug_window_r <= 1'b1;
    else if (ret_i == crs_pkg::CRS_RET_DEBUG)
      debug_window_r <= 1'b0;
  end

  always_comb
  begin
    if (sr_idx_i == `CRS_SR_IRQ_PC)
      sr_rdata_nxt = irq_saved_counter_r;
    else if (sr_idx_i == `CRS_SR_IRQ_PSW)
      sr_rdata_nxt = crs_psw_ext(irq_saved_status_r);
    else if (sr_idx_i == `CRS_SR_NMI_PC)
      sr_rdata_nxt = nmi_saved_counter_r;
    else if (sr_idx_i == `CRS_SR_NMI_PSW)
      sr_rdata_nxt = crs_psw_ext(nmi_saved_status_r);
    else if (sr_idx_i == `CRS_SR_CAUSE)
      sr_rdata_nxt = exception_cause_r;
    else if (sr_idx_i == `CRS_SR_PSW)
      sr_rdata_nxt = crs_psw_ext(program_status_word_r);
    else if (sr_idx_i == `CRS_SR_TC_PC)
      sr_rdata_nxt = table_call_saved_counter_r;
    else if (sr_idx_i == `CRS_SR_TC_PSW)
      sr_rdata_nxt = crs_psw_ext(table_call_saved_status_r);
    else if (sr_idx_i == `CRS_SR_DBG_PC && debug_window_r)
      sr_rdata_nxt = debug_trap_saved_counter_r;
    else if (sr_idx_i == `CRS_SR_DBG_PSW && debug_window_r)
      sr_rdata_nxt = crs_psw_ext(debug_trap_saved_status_r);
    else if (sr_idx_i == `CRS_SR_TC_BASE)
      sr_rdata_nxt = table_call_base_r;
    else
      sr_rdata_nxt = '0;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sr_rdata_o <= `CRS_WORD_RST;
    else
      sr_rdata_o <= sr_rdata_nxt;
  end

  assign psw_o = program_status_word_r;
  assign debug_window_o = debug_window_r;

  // ==========================================================================
  // program counter
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pc_r <= {{(XLEN-`CRS_PC_BITS){1'b0}}, `CRS_PC_RST};
    else if (ret_i == crs_pkg::CRS_RET_IRQ)
      pc_r <= irq_saved_counter_r;
    else if (ret_i == crs_pkg::CRS_RET_NMI)
      pc_r <= nmi_saved_counter_r;
    else if (ret_i == crs_pkg::CRS_RET_DEBUG)
      pc_r <= debug_trap_saved_counter_r;
    else if (ret_i == crs_pkg::CRS_RET_TABLE_CALL)
      pc_r <= table_call_saved_counter_r;
    else if (pc_load_i)
      pc_r <= crs_pc_fix(pc_target_i);
    else if (pc_advance_i)
      pc_r <= crs_pc_fix(pc_r + {{(XLEN-3){1'b0}}, pc_step_i});
  end

  assign pc_o = pc_r;
  assign fetch_addr_o = pc_r[`CRS_PC_BITS-1:0];

  // ==========================================================================
  // pipeline occupancy: one slot enters and one leaves every clock
  logic [PIPE_STAGES-1:0] stage_r;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      stage_r <= '0;
    else
      stage_r <= {stage_r[PIPE_STAGES-2:0], issue_i};
  end

  assign retire_o = stage_r[PIPE_STAGES-1];

endmodule : crs_regs

// *** crs_regs_checker.sv ***
`timescale 1ns/1ps
`include "crs_defines.svh"

module crs_regs_checker #(
  parameter int XLEN = 32,
  parameter int NGPR = 32,
  parameter int PIPE_STAGES = 5
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // read ports
  input wire logic [`CRS_IDX_W-1:0] rd_a_idx_i,
  input wire logic [`CRS_IDX_W-1:0] rd_b_idx_i,
  input wire logic [XLEN-1:0] rd_a_data_o,
  input wire logic [XLEN-1:0] rd_b_data_o,
  // shift and bit unit
  input wire crs_pkg::crs_op_t op_i,
  input wire logic [XLEN-1:0] op_operand_i,
  input wire logic [`CRS_SHAMT_W-1:0] op_amount_i,
  input wire logic [XLEN-1:0] op_result_o,
  // program counter and events
  input wire logic pc_load_i,
  input wire logic [XLEN-1:0] pc_target_i,
  input wire logic pc_advance_i,
  input wire logic [2:0] pc_step_i,
  input wire logic [XLEN-1:0] pc_o,
  input wire logic [`CRS_PC_BITS-1:0] fetch_addr_o,
  input wire crs_pkg::crs_evt_t evt_i,
  input wire crs_pkg::crs_ret_t ret_i,
  input wire logic debug_window_o,
  // pipeline
  input wire logic issue_i,
  input wire logic retire_o
);
  localparam logic [31:0] PCM = 32'h03FF_FFFE;

  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // ======================================
  // register file
  a_zero_read_a: assert property (rd_a_idx_i == 5'h00 |=> rd_a_data_o == '0)
    else $error("zero register read nonzero on port a");
  a_zero_read_b: assert property (rd_b_idx_i == 5'h00 |=> rd_b_data_o == '0)
    else $error("zero register read nonzero on port b");

  // ======================================
  // pipeline and counter
  a_retire_follow: assert property (issue_i |-> ##5 retire_o)
    else $error("issued slot did not retire five clocks later");
  a_retire_idle: assert property (!issue_i |-> ##5 !retire_o)
    else $error("retire without an issue");
  a_pc_fixed_bits: assert property (pc_o[31:26] == 6'h00 && !pc_o[0]
    && fetch_addr_o == pc_o[25:0])
    else $error("counter fixed bits or fetch address wrong");
  a_pc_load_mask: assert property (pc_load_i && ret_i == crs_pkg::CRS_RET_NONE
    |=> pc_o == ($past(pc_target_i) & PCM))
    else $error("counter load not masked target");
  a_pc_step_wrap: assert property (!pc_load_i && pc_advance_i
    && ret_i == crs_pkg::CRS_RET_NONE
    |=> pc_o == (($past(pc_o) + $past(pc_step_i)) & PCM))
    else $error("counter advance wrong");
  a_pc_hold_idle: assert property (!pc_load_i && !pc_advance_i
    && ret_i == crs_pkg::CRS_RET_NONE |=> $stable(pc_o))
    else $error("counter moved while idle");

  // ======================================
  // left shift, idle result hold, debug window
  a_shift_one_clk: assert property (op_i == crs_pkg::CRS_OP_SHL
    |=> op_result_o == ($past(op_operand_i) << $past(op_amount_i)))
    else $error("left shift result wrong after one clock");
  a_op_none_hold: assert property (op_i == crs_pkg::CRS_OP_NONE |=> $stable(op_result_o))
    else $error("result changed without an operation");
  a_debug_open: assert property (evt_i == crs_pkg::CRS_EVT_DEBUG |=> debug_window_o)
    else $error("debug window not opened by debug entry");
endmodule : crs_regs_checker

bind crs_regs crs_regs_checker #(.XLEN(XLEN), .NGPR(NGPR), .PIPE_STAGES(PIPE_STAGES))
  crs_regs_checker_inst (.clk_i, .nrst_i, .rd_a_idx_i, .rd_b_idx_i, .rd_a_data_o,
  .rd_b_data_o, .op_i, .op_operand_i, .op_amount_i, .op_result_o, .pc_load_i,
  .pc_target_i, .pc_advance_i, .pc_step_i, .pc_o, .fetch_addr_o, .evt_i, .ret_i,
  .debug_window_o, .issue_i, .retire_o);

// *** crs_pipe_model.sv ***
`timescale 1ns/1ps

module crs_pipe_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // issue stream and its expected retirement
  output logic issue_o,
  output logic retire_exp_o
);
  logic [4:0] stage_r;

  // ======================================
  // random issue, one slot per stage
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      issue_o <= 1'b0;
    else
      issue_o <= 1'($urandom);

  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      stage_r <= 5'h00;
    else
      stage_r <= {stage_r[3:0], issue_o};

  assign retire_exp_o = stage_r[4];
endmodule : crs_pipe_model

// *** tb_crs_regs.sv ***
`timescale 1ns/1ps
`include "crs_defines.svh"

module tb_crs_regs;
  typedef struct {int s; logic [31:0] v; int d;} crs_note_t;
  localparam logic [31:0] PCM = 32'h03FF_FFFE;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wr_en_i = 1'b0;
  logic addr_req_i = 1'b0;
  logic short_fmt_i = 1'b0;
  logic pc_load_i = 1'b0;
  logic pc_advance_i = 1'b0;
  logic sr_wr_i = 1'b0;
  logic [4:0] rd_a_idx_i = 5'h00, rd_b_idx_i = 5'h00, wr_idx_i = 5'h00;
  logic [4:0] op_amount_i = 5'h00, sr_idx_i = 5'h00, a;
  logic [31:0] wr_data_i = 32'h0, addr_offset_i = 32'h0, op_operand_i = 32'h0;
  logic [31:0] pc_target_i = 32'h0, sr_wdata_i = 32'h0, evt_pc_i = 32'h0, evt_cause_i = 32'h0;
  logic [2:0] pc_step_i = 3'h0;
  crs_pkg::crs_op_t op_i = crs_pkg::CRS_OP_NONE;
  crs_pkg::crs_evt_t evt_i = crs_pkg::CRS_EVT_NONE;
  crs_pkg::crs_ret_t ret_i = crs_pkg::CRS_RET_NONE;
  logic [31:0] rd_a_data_o, rd_b_data_o, data_addr_o, op_result_o, pc_o, sr_rdata_o;
  logic [25:0] fetch_addr_o;
  logic [7:0] psw_o, pm;
  logic op_bit_zero_o, debug_window_o, retire_o, issue_i, exp_ret;
  logic [31:0] g [32], r, p, e;
  logic [4:0] sx [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h10, 5'h11,
    5'h12, 5'h14, 5'h1F};
  logic [31:0] sm [12] = '{PCM, 32'h0000_00FF, PCM, 32'h0000_00FF, 32'h0, 32'h0000_00FF,
    32'h0, PCM, 32'h0000_00FF, 32'h0, PCM, 32'h0};
  int failures = 0, check_count = 0, cyc = 0;
  crs_note_t q[$];

  crs_regs crs_regs_inst (.clk_i, .nrst_i, .rd_a_idx_i, .rd_b_idx_i, .rd_a_data_o, .rd_b_data_o,
    .wr_en_i, .wr_idx_i, .wr_data_i, .addr_req_i, .short_fmt_i, .addr_offset_i, .data_addr_o,
    .op_i, .op_operand_i, .op_amount_i, .op_result_o, .op_bit_zero_o, .pc_load_i, .pc_target_i,
    .pc_advance_i, .pc_step_i, .pc_o, .fetch_addr_o, .sr_wr_i, .sr_idx_i, .sr_wdata_i,
    .sr_rdata_o, .psw_o, .debug_window_o, .evt_i, .evt_pc_i, .evt_cause_i, .ret_i, .issue_i,
    .retire_o);
  crs_pipe_model crs_pipe_model_inst (.clk_i, .nrst_i, .issue_o(issue_i), .retire_exp_o(exp_ret));

  initial
    forever #25 clk_i = ~clk_i;

  // ======================================
  // checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // result is due at the edge that takes the request, one edge after the one that drives it, plus x
  task automatic note(input int s, input logic [31:0] v, input int x);
    q.push_back('{s, v, cyc + 2 + x});
  endtask : note

  function automatic logic [31:0] opx(input int k, input logic [31:0] v, input logic [4:0] n);
    case (k)
      1: return v << n;
      2: return v >> n;
      3: return $signed(v) >>> n;
      4: return v | (32'h1 << n[2:0]);
      5: return v & ~(32'h1 << n[2:0]);
      6: return v ^ (32'h1 << n[2:0]);
      default: return v;
    endcase
  endfunction : opx

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      failures++;
      end_sim();
    end
  end

  always @(negedge clk_i)
  begin
    if (nrst_i)
      check({31'h0, retire_o}, {31'h0, exp_ret});
    for (int i = q.size() - 1; i >= 0; i--)
      if (q[i].d <= cyc)
      begin
        case (q[i].s)
          0: check(rd_a_data_o, q[i].v);
          1: check(rd_b_data_o, q[i].v);
          2: check(data_addr_o, q[i].v);
          3: check(op_result_o, q[i].v);
          4: check({31'h0, op_bit_zero_o}, q[i].v);
          5:
          begin
            check(pc_o, q[i].v);
            check({6'h0, fetch_addr_o}, q[i].v);
          end
          6: check(sr_rdata_o, q[i].v);
          7: check({24'h0, psw_o}, q[i].v);
          default: check({31'h0, debug_window_o}, q[i].v);
        endcase
        q.delete(i);
      end
  end

  // ======================================
  // stimulus
  initial
  begin
    void'($urandom(32'h1bd5_b2bf));
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    check({24'h0, psw_o}, 32'h0000_0020);
    // every index written, zero included, then read back on both ports
    for (int i = 0; i < 32; i++)
    begin
      @(posedge clk_i);
      r = $urandom;
      g[i] = (i == 0) ? 32'h0 : r;
      wr_en_i <= 1'b1;
      wr_idx_i <= 5'(i);
      wr_data_i <= r;
    end
    for (int i = 0; i < 32; i++)
    begin
      @(posedge clk_i);
      wr_en_i <= 1'b0;
      rd_a_idx_i <= 5'(i);
      rd_b_idx_i <= 5'(31 - i);
      note(0, g[i], 0);
      note(1, g[31 - i], 0);
    end
    @(posedge clk_i);
    r = $urandom;
    addr_req_i <= 1'b1;
    short_fmt_i <= 1'b1;
    addr_offset_i <= r;
    note(2, g[30] + r, 0);
    @(posedge clk_i);
    short_fmt_i <= 1'b0;
    rd_a_idx_i <= 5'h07;
    addr_offset_i <= 32'hFFFF_FFFC;
    note(2, g[7] + 32'hFFFF_FFFC, 0);
    @(posedge clk_i);
    addr_req_i <= 1'b0;
    note(2, g[7] + 32'hFFFF_FFFC, 1);
    for (int k = 1; k < 15; k++)
    begin
      @(posedge clk_i);
      r = $urandom;
      a = 5'($urandom);
      e = opx(k % 8 == 0 ? 1 : k % 8, r, a);
      op_i <= crs_pkg::crs_op_t'(3'(k % 8 == 0 ? 1 : k % 8));
      op_operand_i <= r;
      op_amount_i <= a;
      note(3, e, 0);
      if (k % 8 > 3)
        note(4, {31'h0, ~r[a[2:0]]}, 0);
    end
    @(posedge clk_i);
    op_i <= crs_pkg::CRS_OP_NONE;
    note(3, e, 0);
    // load beats advance; advance carries past bit 25 and wraps
    @(posedge clk_i);
    pc_load_i <= 1'b1;
    pc_target_i <= 32'h0400_0003;
    note(5, 32'h0000_0002, 0);
    @(posedge clk_i);
    pc_target_i <= 32'h03FF_FFFE;
    pc_advance_i <= 1'b1;
    pc_step_i <= 3'h4;
    note(5, 32'h03FF_FFFE, 0);
    @(posedge clk_i);
    pc_load_i <= 1'b0;
    note(5, 32'h0000_0002, 0);
    @(posedge clk_i);
    pc_advance_i <= 1'b0;
    note(5, 32'h0000_0002, 1);
    foreach (sx[j])
    begin
      @(posedge clk_i);
      r = $urandom;
      if (sm[j] == PCM)
        r = r & PCM;
      sr_wr_i <= 1'b1;
      sr_idx_i <= sx[j];
      sr_wdata_i <= r;
      if (sx[j] == 5'h05)
      begin
        pm = r[7:0];
        note(7, {24'h0, pm}, 0);
      end
      @(posedge clk_i);
      sr_wr_i <= 1'b0;
      note(6, r & sm[j], 0);
    end
    // interrupt, non-maskable and table-call entries; a same-cycle write is dropped
    // a table call leaves the cause alone, so the earlier cause must survive it
    for (int k = 1; k < 4; k++)
    begin
      @(posedge clk_i);
      p = $urandom;
      if (k < 3)
        r = $urandom;
      a = (k < 3) ? 5'(2 * k - 2) : 5'h10;
      evt_i <= crs_pkg::crs_evt_t'(3'(k < 3 ? k : 4));
      evt_pc_i <= p;
      evt_cause_i <= (k < 3) ? r : ~r;
      sr_wr_i <= 1'b1;
      sr_idx_i <= a;
      sr_wdata_i <= 32'h0000_0010;
      @(posedge clk_i);
      evt_i <= crs_pkg::CRS_EVT_NONE;
      sr_wr_i <= 1'b0;
      note(6, p & PCM, 0);
      @(posedge clk_i);
      sr_idx_i <= 5'h04;
      note(6, r, 0);
      @(posedge clk_i);
      sr_idx_i <= a + 5'h01;
      note(6, {24'h0, pm}, 0);
      @(posedge clk_i);
      ret_i <= crs_pkg::crs_ret_t'(3'(k < 3 ? k : 4));
      note(5, p & PCM, 0);
      note(7, {24'h0, pm}, 0);
      @(posedge clk_i);
      ret_i <= crs_pkg::CRS_RET_NONE;
    end
    @(posedge clk_i);
    p = $urandom;
    evt_i <= crs_pkg::CRS_EVT_DEBUG;
    evt_pc_i <= p;
    note(8, 32'h1, 0);
    @(posedge clk_i);
    evt_i <= crs_pkg::CRS_EVT_NONE;
    sr_idx_i <= 5'h12;
    note(6, p & PCM, 0);
    @(posedge clk_i);
    ret_i <= crs_pkg::CRS_RET_DEBUG;
    note(8, 32'h0, 0);
    note(5, p & PCM, 0);
    @(posedge clk_i);
    ret_i <= crs_pkg::CRS_RET_NONE;
    repeat (8) @(posedge clk_i);
    // a second reset in mid-run clears the counter and reloads the status word
    nrst_i <= 1'b0;
    @(posedge clk_i);
    check(pc_o, 32'h0000_0000);
    check({24'h0, psw_o}, 32'h0000_0020);
    end_sim();
  end
endmodule : tb_crs_regs
